/* rtl/aoscl_regs.vh */
// Register map, field codes, limits and timing constants of the analogue output scaler
`ifndef AOSCL_REGS_VH
`define AOSCL_REGS_VH

// ==========================================================
// Register offsets (word addresses on the plain port)
`define AOSCL_ADDR_W          4
`define AOSCL_REG_CTRL        4'h0
`define AOSCL_REG_LOW_EP      4'h1
`define AOSCL_REG_HIGH_EP     4'h2
`define AOSCL_REG_EXT         4'h3
`define AOSCL_REG_BUS_SRC     4'h4
`define AOSCL_REG_STATUS      4'h5
`define AOSCL_REG_RESULT      4'h6

// ==========================================================
// CTRL fields
`define AOSCL_CTRL_SRC_LSB    0
`define AOSCL_CTRL_MODE_LSB   2
`define AOSCL_CTRL_ALARM_LSB  5
`define AOSCL_CTRL_HOLD_BIT   8
`define AOSCL_CTRL_KIND_LSB   9
`define AOSCL_CTRL_RESET      32'h0000_0000

// Source selector codes
`define AOSCL_SRC_MEAS        2'h0
`define AOSCL_SRC_BUS         2'h1
`define AOSCL_SRC_CPOS        2'h2
`define AOSCL_SRC_CNEG        2'h3

// Output kind codes
`define AOSCL_KIND_ACT_CUR    2'h0
`define AOSCL_KIND_PAS_CUR    2'h1
`define AOSCL_KIND_ACT_VOLT   2'h2

// Output mode codes
`define AOSCL_MODE_OFF        3'h0
`define AOSCL_MODE_4_20       3'h1
`define AOSCL_MODE_0_20       3'h2
`define AOSCL_MODE_0_5        3'h3
`define AOSCL_MODE_1_5        3'h4
`define AOSCL_MODE_0_10       3'h5
`define AOSCL_MODE_2_10       3'h6

// Alarm level codes
`define AOSCL_AL_HOLD         3'h0
`define AOSCL_AL_HIGH         3'h1
`define AOSCL_AL_MID          3'h2
`define AOSCL_AL_LOW          3'h3
`define AOSCL_AL_V06          3'h4
`define AOSCL_AL_ZERO         3'h5

// ==========================================================
// Output units: microamps or millivolts, 16 bits
`define AOSCL_OUT_W           16
`define AOSCL_U_0             16'h0000
`define AOSCL_U_1000          16'h03E8
`define AOSCL_U_2000          16'h07D0
`define AOSCL_U_4000          16'h0FA0
`define AOSCL_U_5000          16'h1388
`define AOSCL_U_10000         16'h2710
`define AOSCL_U_20000         16'h4E20
`define AOSCL_AL_22100        16'h5654
`define AOSCL_AL_3400         16'h0D48
`define AOSCL_AL_11000        16'h2AF8
`define AOSCL_AL_5500         16'h157C
`define AOSCL_AL_1200         16'h04B0
`define AOSCL_AL_600          16'h0258

// Extension limits in tenths of a percent
`define AOSCL_EXT_W           10
`define AOSCL_LO_MAX_ACT      10'h3E7
`define AOSCL_LO_MAX_PAS      10'h12B
`define AOSCL_HI_MAX_CUR      10'h0C7
`define AOSCL_HI_MAX_VOLT     10'h063
`define AOSCL_PERMILLE        16'h03E8

// Divider length: one cycle per quotient bit
`define AOSCL_DIV_STEPS       6'h20

`endif

/* rtl/aoscl_clamp.v */
// Limit and extended range lookup for the selected output mode
`timescale 1ns/1ps
`default_nettype none
`include "aoscl_regs.vh"

module aoscl_clamp (
  input  wire [2:0]                 mode_in,
  input  wire [1:0]                 kind_in,
  input  wire [`AOSCL_EXT_W-1:0]    lo_pct_in,
  input  wire [`AOSCL_EXT_W-1:0]    hi_pct_in,
  output reg  [`AOSCL_OUT_W-1:0]    lower_out,
  output reg  [`AOSCL_OUT_W-1:0]    upper_out,
  output reg  [`AOSCL_OUT_W-1:0]    ext_lo_out,
  output reg  [`AOSCL_OUT_W-1:0]    ext_hi_out,
  output reg                        enable_out
);

  reg [`AOSCL_EXT_W-1:0] lo_cap;
  reg [`AOSCL_EXT_W-1:0] hi_cap;
  reg [`AOSCL_EXT_W-1:0] lo_eff;
  reg [`AOSCL_EXT_W-1:0] hi_eff;
  reg [31:0]             lo_prod;
  reg [31:0]             hi_prod;
  reg [31:0]             lo_drop;
  reg [31:0]             hi_gain;

  // ==========================================================
  // Range limits per mode
  always @* begin
    lower_out  = `AOSCL_U_0;
    upper_out  = `AOSCL_U_0;
    enable_out = 1'b1;
    case (mode_in)
      `AOSCL_MODE_4_20: begin lower_out = `AOSCL_U_4000; upper_out = `AOSCL_U_20000; end
      `AOSCL_MODE_0_20: begin upper_out = `AOSCL_U_20000; enable_out = (kind_in == `AOSCL_KIND_ACT_CUR); end
      `AOSCL_MODE_0_5:  begin upper_out = `AOSCL_U_5000; enable_out = (kind_in == `AOSCL_KIND_ACT_VOLT); end
      `AOSCL_MODE_1_5:  begin lower_out = `AOSCL_U_1000; upper_out = `AOSCL_U_5000;
                              enable_out = (kind_in == `AOSCL_KIND_ACT_VOLT); end
      `AOSCL_MODE_0_10: begin upper_out = `AOSCL_U_10000; enable_out = (kind_in == `AOSCL_KIND_ACT_VOLT); end
      `AOSCL_MODE_2_10: begin lower_out = `AOSCL_U_2000; upper_out = `AOSCL_U_10000;
                              enable_out = (kind_in == `AOSCL_KIND_ACT_VOLT); end
      default:          enable_out = 1'b0;
    endcase
    if (mode_in == `AOSCL_MODE_4_20 && kind_in == `AOSCL_KIND_ACT_VOLT)
      enable_out = 1'b0;
  end

  // ==========================================================
  // Extended range in permille steps; settings above the kind's ceiling are capped
  always @* begin
    lo_cap = (kind_in == `AOSCL_KIND_PAS_CUR) ? `AOSCL_LO_MAX_PAS : `AOSCL_LO_MAX_ACT;
    hi_cap = (kind_in == `AOSCL_KIND_ACT_VOLT) ? `AOSCL_HI_MAX_VOLT : `AOSCL_HI_MAX_CUR;
    lo_eff = (lo_pct_in > lo_cap) ? lo_cap : lo_pct_in;
    hi_eff = (hi_pct_in > hi_cap) ? hi_cap : hi_pct_in;
    lo_prod = {16'h0000, lower_out} * {22'h00_0000, lo_eff};
    hi_prod = {16'h0000, upper_out} * {22'h00_0000, hi_eff};
    lo_drop    = lo_prod / {16'h0000, `AOSCL_PERMILLE};
    hi_gain    = hi_prod / {16'h0000, `AOSCL_PERMILLE};
    ext_lo_out = lower_out - lo_drop[15:0];
    ext_hi_out = upper_out + hi_gain[15:0];
  end

endmodule // aoscl_clamp
`default_nettype wire

/* rtl/aoscl_divider.v */
// Restoring unsigned divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
`include "aoscl_regs.vh"

module aoscl_divider (
  input  wire        clk_in,
  input  wire        reset_n_in,
  input  wire        start_in,
  input  wire [31:0] dividend_in,
  input  wire [31:0] divisor_in,
  output reg  [31:0] quotient_out,
  output reg         done_out
);

  reg [31:0] rem_q;
  reg [31:0] num_q;
  reg [31:0] den_q;
  reg [5:0]  cnt_q;
  reg        busy_q;
  reg [32:0] trial;

  always @* begin
    trial = {rem_q, num_q[31]} - {1'b0, den_q};
  end

  always @(posedge clk_in) begin
    done_out <= 1'b0;
    if (!reset_n_in) begin
      rem_q        <= 32'h0000_0000;
      num_q        <= 32'h0000_0000;
      den_q        <= 32'h0000_0000;
      cnt_q        <= 6'h00;
      busy_q       <= 1'b0;
      quotient_out <= 32'h0000_0000;
    end else if (start_in) begin
      rem_q  <= 32'h0000_0000;
      num_q  <= dividend_in;
      den_q  <= divisor_in;
      cnt_q  <= `AOSCL_DIV_STEPS;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (!trial[32]) begin
        rem_q <= trial[31:0];
        num_q <= {num_q[30:0], 1'b1};
      end else begin
        rem_q <= {rem_q[30:0], num_q[31]};
        num_q <= {num_q[30:0], 1'b0};
      end
      cnt_q <= cnt_q - 6'h01;
      if (cnt_q == 6'h01) begin
        busy_q       <= 1'b0;
        done_out     <= 1'b1;
        quotient_out <= trial[32] ? {num_q[30:0], 1'b0} : {num_q[30:0], 1'b1};
      end
    end
  end

endmodule // aoscl_divider
`default_nettype wire

/* rtl/aoscl_top.v */
// Analogue output scaler: source select, linear map, range clamp and alarm level
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "aoscl_regs.vh"

module aoscl_top (
  input  wire                       CLOCK_IN,
  input  wire                       RESET_N_IN,
  input  wire [`AOSCL_ADDR_W-1:0]   ADDR_IN,
  input  wire [31:0]                WDATA_IN,
  input  wire                       WRITE_IN,
  input  wire                       READ_IN,
  output reg  [31:0]                RDATA_OUT,
  input  wire [15:0]                MEAS_VALUE_IN,
  input  wire [15:0]                PEAK_VALUE_IN,
  input  wire                       MEAS_VALID_IN,
  input  wire [15:0]                CTRL_OUTPUT_IN,
  input  wire                       CTRL_VALID_IN,
  input  wire                       RANGE_EXCEEDED_IN,
  input  wire                       SENSOR_FAULT_IN,
  output reg  [`AOSCL_OUT_W-1:0]    DAC_VALUE_OUT,
  output reg                        DAC_ENABLE_OUT,
  output reg                        DAC_UPDATE_OUT,
  output reg                        ALARM_ACTIVE_OUT
);

  // ==========================================================
  // Registers
  reg  [31:0]               ctrl_q;
  reg  [15:0]               low_endpoint_q;
  reg  [15:0]               high_endpoint_q;
  reg  [`AOSCL_EXT_W-1:0]   low_extension_pct_q;
  reg  [`AOSCL_EXT_W-1:0]   high_extension_pct_q;
  reg  [15:0]               bus_value_q;
  reg                       bus_new_q;
  reg  [`AOSCL_OUT_W-1:0]   computed_q;
  reg                       busy_q;
  reg                       neg_q;
  reg                       sticky_alarm_q;

  wire [1:0]                output_source_select = ctrl_q[`AOSCL_CTRL_SRC_LSB+1:`AOSCL_CTRL_SRC_LSB];
  wire [2:0]                out_mode             = ctrl_q[`AOSCL_CTRL_MODE_LSB+2:`AOSCL_CTRL_MODE_LSB];
  wire [2:0]                alarm_output_level   = ctrl_q[`AOSCL_CTRL_ALARM_LSB+2:`AOSCL_CTRL_ALARM_LSB];
  wire                      output_hold_select   = ctrl_q[`AOSCL_CTRL_HOLD_BIT];
  wire [1:0]                out_kind             = ctrl_q[`AOSCL_CTRL_KIND_LSB+1:`AOSCL_CTRL_KIND_LSB];

  // Range limits and extended range from the mode lookup
  wire [`AOSCL_OUT_W-1:0]   lower_lim;
  wire [`AOSCL_OUT_W-1:0]   upper_lim;
  wire [`AOSCL_OUT_W-1:0]   ext_lo;
  wire [`AOSCL_OUT_W-1:0]   ext_hi;
  wire                      mode_on;
  wire [31:0]               quotient;
  wire                      div_done;

  aoscl_clamp u_clamp (
    .mode_in    (out_mode),
    .kind_in    (out_kind),
    .lo_pct_in  (low_extension_pct_q),
    .hi_pct_in  (high_extension_pct_q),
    .lower_out  (lower_lim),
    .upper_out  (upper_lim),
    .ext_lo_out (ext_lo),
    .ext_hi_out (ext_hi),
    .enable_out (mode_on)
  );

  // ==========================================================
  // Source selection
  reg  [15:0]  src_meas;
  reg  [15:0]  src_sel;
  reg          src_new;
  reg  [15:0]  ctrl_mag;
  always @* begin
    // The hold setting picks the held peak instead of the present value
    src_meas = output_hold_select ? PEAK_VALUE_IN : MEAS_VALUE_IN;
    ctrl_mag = 16'h0000;
    case (output_source_select)
      `AOSCL_SRC_MEAS: begin
        src_sel = src_meas;
        src_new = MEAS_VALID_IN;
      end
      `AOSCL_SRC_BUS: begin
        src_sel = bus_value_q;
        src_new = bus_new_q;
      end
      // Controller halves are magnitudes; the unused half reads as zero
      `AOSCL_SRC_CPOS: begin
        ctrl_mag = CTRL_OUTPUT_IN[15] ? 16'h0000 : CTRL_OUTPUT_IN;
        src_sel  = ctrl_mag;
        src_new  = CTRL_VALID_IN;
      end
      `AOSCL_SRC_CNEG: begin
        ctrl_mag = CTRL_OUTPUT_IN[15] ? 16'h0000 - CTRL_OUTPUT_IN : 16'h0000;
        src_sel  = ctrl_mag;
        src_new  = CTRL_VALID_IN;
      end
      default: begin
        src_sel = src_meas;
        src_new = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Scaling set-up: |W-L| * (B-A) / |H-L|, sign from the two differences
  wire signed [16:0] w_minus_l = $signed({src_sel[15], src_sel}) - $signed({low_endpoint_q[15], low_endpoint_q});
  wire signed [16:0] h_minus_l = $signed({high_endpoint_q[15], high_endpoint_q})
                                 - $signed({low_endpoint_q[15], low_endpoint_q});
  wire [16:0]        num_mag   = w_minus_l[16] ? 17'h0_0000 - w_minus_l : w_minus_l;
  wire [16:0]        den_mag   = h_minus_l[16] ? 17'h0_0000 - h_minus_l : h_minus_l;
  wire [15:0]        span      = upper_lim - lower_lim;
  // Product fits 32 bits: a 17-bit magnitude times a span below 2^15
  wire [32:0]        product   = {16'h0000, num_mag} * {17'h0_0000, span};
  // Equal endpoints bypass the divider, which has no answer for a zero divisor
  wire               start     = src_new && !busy_q && (h_minus_l != 17'h0_0000);
  wire               eq_ep     = src_new && (h_minus_l == 17'h0_0000);

  // Divider takes the set-up at start and answers a fixed number of cycles later
  aoscl_divider u_div (
    .clk_in       (CLOCK_IN),
    .reset_n_in   (RESET_N_IN),
    .start_in     (start),
    .dividend_in  (product[31:0]),
    .divisor_in   ({15'h0000, den_mag}),
    .quotient_out (quotient),
    .done_out     (div_done)
  );

  // ==========================================================
  // Result assembly and clamp
  // Wide signed sum so an inverted map that dips below zero still clamps
  reg signed [33:0] out_raw;
  reg [`AOSCL_OUT_W-1:0] clamped;
  always @* begin
    out_raw = neg_q ? $signed({18'h0_0000, lower_lim}) - $signed({2'b00, quotient})
                    : $signed({18'h0_0000, lower_lim}) + $signed({2'b00, quotient});
    if (out_raw < $signed({18'h0_0000, ext_lo}))
      clamped = ext_lo;
    else if (out_raw > $signed({18'h0_0000, ext_hi}))
      clamped = ext_hi;
    else
      clamped = out_raw[15:0];
  end

  // ==========================================================
  // Alarm level; an unavailable choice for the output kind falls back to hold
  // Both fault inputs are levels; the alarm lasts while either stays high
  wire critical = RANGE_EXCEEDED_IN || SENSOR_FAULT_IN;
  reg  [`AOSCL_OUT_W-1:0] alarm_val;
  reg                     alarm_force;
  always @* begin
    alarm_val   = `AOSCL_U_0;
    alarm_force = 1'b1;
    if (out_kind == `AOSCL_KIND_ACT_VOLT) begin
      case (alarm_output_level)
        `AOSCL_AL_HIGH: alarm_val = `AOSCL_AL_11000;
        `AOSCL_AL_MID:  alarm_val = `AOSCL_AL_5500;
        `AOSCL_AL_LOW:  alarm_val = `AOSCL_AL_1200;
        `AOSCL_AL_V06:  alarm_val = `AOSCL_AL_600;
        `AOSCL_AL_ZERO: alarm_val = `AOSCL_U_0;
        default:        alarm_force = 1'b0;
      endcase
    end else begin
      // Zero current is refused on passive outputs and falls back to hold
      case (alarm_output_level)
        `AOSCL_AL_HIGH: alarm_val = `AOSCL_AL_22100;
        `AOSCL_AL_MID:  alarm_val = `AOSCL_AL_3400;
        `AOSCL_AL_ZERO: alarm_force = (out_kind == `AOSCL_KIND_ACT_CUR);
        default:        alarm_force = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Datapath control
  always @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      computed_q <= `AOSCL_U_0;
      busy_q     <= 1'b0;
      neg_q      <= 1'b0;
    end else begin
      // Valids during a divide are dropped; a bus value stays pending until taken
      if (start) begin
        busy_q <= 1'b1;
        neg_q  <= w_minus_l[16] ^ h_minus_l[16];
      end else if (div_done) begin
        busy_q     <= 1'b0;
        computed_q <= clamped;
      end
      if (eq_ep && !busy_q) begin
        computed_q <= lower_lim;
      end
    end
  end

  // ==========================================================
  // Output stage: alarm overrides, computed value returns after it
  always @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      DAC_VALUE_OUT    <= `AOSCL_U_0;
      DAC_ENABLE_OUT   <= 1'b0;
      DAC_UPDATE_OUT   <= 1'b0;
      ALARM_ACTIVE_OUT <= 1'b0;
    end else begin
      ALARM_ACTIVE_OUT <= critical;
      DAC_ENABLE_OUT   <= mode_on;
      DAC_UPDATE_OUT   <= 1'b0;
      // Update pulses only on a change, so the converter sees one write per new value
      if (!mode_on) begin
        DAC_VALUE_OUT  <= `AOSCL_U_0;
        DAC_UPDATE_OUT <= (DAC_VALUE_OUT != `AOSCL_U_0);
      end else if (critical) begin
        if (alarm_force) begin
          DAC_VALUE_OUT  <= alarm_val;
          DAC_UPDATE_OUT <= (DAC_VALUE_OUT != alarm_val);
        end
      end else if (DAC_VALUE_OUT != computed_q) begin
        DAC_VALUE_OUT  <= computed_q;
        DAC_UPDATE_OUT <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Register port: bus writes set a flag; a new write wins over the consume
  always @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      ctrl_q               <= `AOSCL_CTRL_RESET;
      low_endpoint_q       <= 16'h0000;
      high_endpoint_q      <= 16'h0000;
      low_extension_pct_q  <= 10'h000;
      high_extension_pct_q <= 10'h000;
      bus_value_q          <= 16'h0000;
      bus_new_q            <= 1'b0;
      sticky_alarm_q       <= 1'b0;
      RDATA_OUT            <= 32'h0000_0000;
    end else begin
      if (output_source_select == `AOSCL_SRC_BUS && (start || (eq_ep && !busy_q)))
        bus_new_q <= 1'b0;
      if (critical)
        sticky_alarm_q <= 1'b1;
      // Control keeps only its defined bits; the rest read back as zero
      if (WRITE_IN) begin
        case (ADDR_IN)
          `AOSCL_REG_CTRL:    ctrl_q <= {21'h00_0000, WDATA_IN[10:0]};
          `AOSCL_REG_LOW_EP:  low_endpoint_q <= WDATA_IN[15:0];
          `AOSCL_REG_HIGH_EP: high_endpoint_q <= WDATA_IN[15:0];
          `AOSCL_REG_EXT: begin
            low_extension_pct_q  <= WDATA_IN[9:0];
            high_extension_pct_q <= WDATA_IN[25:16];
          end
          `AOSCL_REG_BUS_SRC: begin
            bus_value_q <= WDATA_IN[15:0];
            bus_new_q   <= 1'b1;
          end
          // A clear is ignored while the fault persists
          `AOSCL_REG_STATUS:  if (WDATA_IN[1] && !critical) sticky_alarm_q <= 1'b0;
          default: ;
        endcase
      end
      RDATA_OUT <= 32'h0000_0000;
      if (READ_IN) begin
        case (ADDR_IN)
          `AOSCL_REG_CTRL:    RDATA_OUT <= ctrl_q;
          `AOSCL_REG_LOW_EP:  RDATA_OUT <= {16'h0000, low_endpoint_q};
          `AOSCL_REG_HIGH_EP: RDATA_OUT <= {16'h0000, high_endpoint_q};
          `AOSCL_REG_EXT:     RDATA_OUT <= {6'h00, high_extension_pct_q, 6'h00, low_extension_pct_q};
          `AOSCL_REG_BUS_SRC: RDATA_OUT <= {16'h0000, bus_value_q};
          `AOSCL_REG_STATUS:  RDATA_OUT <= {28'h000_0000, mode_on, busy_q, sticky_alarm_q, critical};
          `AOSCL_REG_RESULT:  RDATA_OUT <= {16'h0000, computed_q};
          default:            RDATA_OUT <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // aoscl_top
`default_nettype wire

/* testbench/aoscl_props.sv */
// Port-level assertions for the analogue output scaler
`timescale 1ns/1ps
`default_nettype none
module aoscl_props (
  input wire logic        CLOCK_IN,
  input wire logic        RESET_N_IN,
  input wire logic        WRITE_IN,
  input wire logic        READ_IN,
  input wire logic [31:0] RDATA_OUT,
  input wire logic        MEAS_VALID_IN,
  input wire logic        CTRL_VALID_IN,
  input wire logic        RANGE_EXCEEDED_IN,
  input wire logic        SENSOR_FAULT_IN,
  input wire logic [15:0] DAC_VALUE_OUT,
  input wire logic        DAC_ENABLE_OUT,
  input wire logic        DAC_UPDATE_OUT,
  input wire logic        ALARM_ACTIVE_OUT
);
  logic       crit;
  logic [7:0] idle_q;
  assign crit = RANGE_EXCEEDED_IN | SENSOR_FAULT_IN;
  // ==========================================================
  // Cycles since the last request that may start a computation
  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN || MEAS_VALID_IN || CTRL_VALID_IN || WRITE_IN)
      idle_q <= 8'h00;
    else if (idle_q != 8'hFF)
      idle_q <= idle_q + 8'h01;
  end
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RESET_N_IN);
  // ==========================================================
  // Assertions
  a_rdata_idle: assert property (!$past(READ_IN) |-> RDATA_OUT == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  a_alarm_follow: assert property (ALARM_ACTIVE_OUT == $past(crit))
    else $error("alarm flag does not follow critical inputs");
  a_update_change: assert property (DAC_UPDATE_OUT == (DAC_VALUE_OUT != $past(DAC_VALUE_OUT)))
    else $error("update pulse and value change disagree");
  a_alarm_steady: assert property ($past(crit) && $past(crit, 2) && $past(crit, 3) |-> $stable(DAC_VALUE_OUT))
    else $error("output moved during critical condition");
  a_reset_clear: assert property ($rose(RESET_N_IN) |-> DAC_VALUE_OUT == 16'h0000 && !DAC_ENABLE_OUT
                                  && !DAC_UPDATE_OUT && !ALARM_ACTIVE_OUT)
    else $error("outputs not cleared by reset");
  a_enable_cause: assert property ($changed(DAC_ENABLE_OUT) |-> $past(WRITE_IN) || $past(WRITE_IN, 2)
                                   || $past(WRITE_IN, 3))
    else $error("enable changed without a register write");
  a_update_cause: assert property (DAC_UPDATE_OUT && !ALARM_ACTIVE_OUT && !$past(ALARM_ACTIVE_OUT)
                                   && !$past(ALARM_ACTIVE_OUT, 2) |-> idle_q < 8'h50)
    else $error("output update without a new source value");
  a_update_single: assert property (DAC_UPDATE_OUT && !$changed(ALARM_ACTIVE_OUT)
                                    |=> !DAC_UPDATE_OUT || $changed(ALARM_ACTIVE_OUT))
    else $error("update pulse longer than one cycle");
  c_update: cover property (DAC_UPDATE_OUT);
  c_alarm_on: cover property ($rose(ALARM_ACTIVE_OUT));
  c_alarm_off: cover property ($fell(ALARM_ACTIVE_OUT));
endmodule // aoscl_props
bind aoscl_top aoscl_props u_aoscl_props (.CLOCK_IN, .RESET_N_IN, .WRITE_IN, .READ_IN, .RDATA_OUT, .MEAS_VALID_IN,
  .CTRL_VALID_IN, .RANGE_EXCEEDED_IN, .SENSOR_FAULT_IN, .DAC_VALUE_OUT, .DAC_ENABLE_OUT, .DAC_UPDATE_OUT,
  .ALARM_ACTIVE_OUT);
`default_nettype wire

/* testbench/aoscl_dac_model.sv */
// Behavioural model of the output converter fed by the scaler
`timescale 1ns/1ps
`default_nettype none
module aoscl_dac_model (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic [15:0] value_in,
  input  wire logic        update_in,
  output var  logic [15:0] level_out
);
  // Latches only on the update pulse, so a missed pulse leaves a stale level
  always @(posedge clk_in) begin
    if (!reset_n_in)
      level_out <= 16'h0000;
    else if (update_in)
      level_out <= value_in;
  end
endmodule // aoscl_dac_model
`default_nettype wire

/* testbench/aoscl_top_tb.sv */
// Self-checking bench for the analogue output scaler
`timescale 1ns/1ps
`default_nettype none
module aoscl_top_tb;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, mval = 1'b0, cval = 1'b0, rexc = 1'b0;
  logic        sflt = 1'b0, hold = 1'b0, en;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000, rv;
  logic [15:0] meas = 16'h0000, peak = 16'h0000, ctrl = 16'h0000;
  wire  [31:0] rdata;
  wire  [15:0] dac, lvl;
  wire         dac_en, dac_upd, alarm;
  integer      miscompares = 0, checked = 0, cycles = 0, seed = 93;
  integer      kind, mode, w, p, eff, lo, hi, lp, hp, exp_v, i, s, a;
  integer      km [10] = '{1, 2, 0, 9, 10, 19, 20, 21, 22, 17};
  always #5 clk = ~clk;
  aoscl_top u_aoscl_top (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WRITE_IN(wr),
    .READ_IN(rd), .RDATA_OUT(rdata), .MEAS_VALUE_IN(meas), .PEAK_VALUE_IN(peak), .MEAS_VALID_IN(mval),
    .CTRL_OUTPUT_IN(ctrl), .CTRL_VALID_IN(cval), .RANGE_EXCEEDED_IN(rexc), .SENSOR_FAULT_IN(sflt),
    .DAC_VALUE_OUT(dac), .DAC_ENABLE_OUT(dac_en), .DAC_UPDATE_OUT(dac_upd), .ALARM_ACTIVE_OUT(alarm));
  aoscl_dac_model u_aoscl_dac_model (.clk_in(clk), .reset_n_in(rst_n), .value_in(dac), .update_in(dac_upd),
    .level_out(lvl));
  // ==========================================================
  // Checking and bus tasks
  task automatic end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      end_sim;
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] expv);
    checked = checked + 1;
    if (seen !== expv) begin
      miscompares = miscompares + 1;
      $display("unexpected %s: expected %h seen %h", name, expv, seen);
    end
  endtask
  task automatic bus_wr(input logic [3:0] ad, input logic [31:0] d);
    addr  <= ad;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    @(posedge clk);
  endtask
  task automatic bus_rd(input logic [3:0] ad, output logic [31:0] d);
    addr <= ad;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
    @(posedge clk);
  endtask
  // ==========================================================
  // Reference model in integers
  function automatic integer model(input integer k, m, x, l, h, pl, ph);
    integer lo_lim, hi_lim, o, el, eh;
    lo_lim = (m == 1) ? 4000 : (m == 4) ? 1000 : (m == 6) ? 2000 : 0;
    hi_lim = (m <= 2) ? 20000 : (m <= 4) ? 5000 : 10000;
    pl = (pl > ((k == 1) ? 299 : 999)) ? ((k == 1) ? 299 : 999) : pl;
    ph = (ph > ((k == 2) ? 99 : 199)) ? ((k == 2) ? 99 : 199) : ph;
    o = (l == h) ? lo_lim : (x - l) * (hi_lim - lo_lim) / (h - l) + lo_lim;
    el = lo_lim - lo_lim * pl / 1000;
    eh = hi_lim + hi_lim * ph / 1000;
    return (o < el) ? el : (o > eh) ? eh : o;
  endfunction
  function automatic integer alarm_lvl(input integer k, c, keep);
    case (c)
      1: return (k == 2) ? 11000 : 22100;
      2: return (k == 2) ? 5500 : 3400;
      3: return (k == 2) ? 1200 : keep;
      4: return (k == 2) ? 600 : keep;
      5: return (k == 1) ? keep : 0;
      default: return keep;
    endcase
  endfunction
  function automatic logic [31:0] ctrl_word(input integer c);
    return {21'h0, kind[1:0], hold, c[2:0], mode[2:0], s[1:0]};
  endfunction
  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus_rd(4'h0, rv);
    chk("ctrl reset", rv, 32'h0000_0000);
    bus_wr(4'h0, 32'hFFFF_FFFF);
    bus_rd(4'h0, rv);
    chk("ctrl mask", rv, 32'h0000_07FF);
    bus_rd(4'hF, rv);
    chk("unmapped", rv, 32'h0000_0000);
    for (i = 0; i < 40; i = i + 1) begin
      kind = km[i % 10] / 8;
      mode = km[i % 10] % 8;
      s    = i / 10;
      lo   = (i % 3 == 0) ? 100 : 0;
      hi   = (i % 3 == 0 || i % 7 == 5) ? 0 : 100;
      lp   = $unsigned($random(seed)) % 1024;
      hp   = $unsigned($random(seed)) % 220;
      w    = $random(seed) % 101 + 50;
      p    = $random(seed) % 101 + 50;
      w    = (s == 1) ? (w & 127) : w;
      hold = (s == 0) && (i % 2 == 1);
      eff  = hold ? p : (s >= 2 && w < 0) ? 0 : w;
      en   = (mode != 0) && ((kind == 0) ? (mode <= 2) : (kind == 1) ? (mode == 1) : (mode >= 3));
      bus_wr(4'h1, lo);
      bus_wr(4'h2, hi);
      bus_wr(4'h3, {6'h00, hp[9:0], 6'h00, lp[9:0]});
      bus_wr(4'h0, ctrl_word(0));
      meas <= w;
      peak <= p;
      ctrl <= (s == 3) ? -w : w;
      mval <= 1'b1;
      cval <= 1'b1;
      @(posedge clk);
      mval <= 1'b0;
      cval <= 1'b0;
      @(posedge clk);
      if (s == 1)
        bus_wr(4'h4, w);
      repeat (40) @(posedge clk);
      #1;
      exp_v = model(kind, mode, eff, lo, hi, lp, hp);
      chk("enable", dac_en, en);
      @(posedge clk);
      if (en) begin
        chk("output", dac, exp_v);
        chk("converter", lvl, exp_v);
        bus_rd(4'h6, rv);
        chk("result", rv, exp_v);
        a = i % 6;
        bus_wr(4'h0, ctrl_word(a));
        rexc <= (i % 2 == 1);
        sflt <= (i % 2 == 0);
        repeat (4) @(posedge clk);
        #1;
        chk("alarm level", dac, alarm_lvl(kind, a, exp_v));
        chk("alarm flag", alarm, 1'b1);
        @(posedge clk);
        bus_rd(4'h5, rv);
        chk("status alarm", rv, 32'h0000_000B);
        rexc <= 1'b0;
        sflt <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("resume", dac, exp_v);
        @(posedge clk);
        bus_wr(4'h5, 32'h0000_0002);
        bus_rd(4'h5, rv);
        chk("status clear", rv, 32'h0000_0008);
      end
    end
    end_sim;
  end
endmodule // aoscl_top_tb
`default_nettype wire
